// ==== src/phy_paged_port_vendor_regs.sv ====
// Purpose: Paged register bank (port status, identification, vendor
//          control) behind indices 8 to 15, with the page/port pointer.
// Assumes: APB3 slave, one wait state; pad inputs arrive asynchronously.
// Notes:   Base registers 0 to 6 are not here and answer with PSLVERR.
//
// Behaviour
// - Report port A-pair line state as two-bit code.
// - Report port B-pair line state with same encoding.
// - Child flag one for child; disconnected, disabled, suspended read child.
// - Child flag invalid after bus reset until tree identification done.
// - Connected set after 341 ms stability; bus reset leaves it.
// - Bias set after 52 us continuous incoming bias.
// - Port disable writable; hardware reset clears; bus reset keeps.
// - Three-bit peer speed code, detection capped at S400.
// - Peer speed invalid after bus reset until self identification done.
// - With enable set, port events set the event flag for the link.
// - Suspend/resume fault sets flag and leaves port suspended.
// - Resume fault when resuming port sees no incoming bias.
// - Suspend fault when suspending port still sees bias.
// - Writing one clears fault; hardware reset clears; bus reset keeps.
// - First identification register returns compliance level 01h.
// - Maker code over three registers, MSB at index 10.
// - Part identifier over three registers, MSB at index 13.
// - Vendor page: null hold, link speed at 8; soft reset at 14.
// - Page and port pointers in register 7; hardware reset clears.
// - Unimplemented port reads zero on whole port status page.
// - Link speed encodes S100..S400; reset value 10b.
// - Writing soft reset forces full device reset; reads zero.
//
// Local design decision: the APB slave port.
`default_nettype none
`include "phy_paged_defs.svh"

module phy_paged_port_vendor_regs
  import phy_paged_pkg::*;
#(
  parameter int unsigned CON_CYC = `CON_DEBOUNCE_CYC,
  parameter int unsigned BIAS_CYC = `BIAS_DEBOUNCE_CYC,
  // Arbitrary neutral identity values.
  parameter logic [23:0] MAKER_OUI = 24'h5AA501,
  parameter logic [23:0] PART_IDENTIFIER = 24'hC33C00
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [1:0] TWISTED_PAIR_A,
  input wire logic [1:0] TWISTED_PAIR_B,
  input wire logic CONNECT_RAW,
  input wire logic BIAS_RAW,
  input wire port_ctl_in_t PORT_CTL,
  input wire logic PORT_EVENT_IRQ_CLR,
  output logic PORT_EVENT_IRQ_FLAG,
  output logic PORT_DISABLE,
  output logic FORCE_SUSPEND,
  output vendor_ctrl_t VENDOR_CTRL,
  output logic SOFT_HARD_RESET
);

  // ************************************************************
  // Reset and bus decode
  // ************************************************************
  logic soft_rst_ff;
  logic rst_all;
  logic pready_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [2:0] page_pointer_ff;
  logic [3:0] port_pointer_ff;
  logic [5:0] idx;
  logic acc;
  logic wr;
  logic mapped;
  logic port_ok;

  assign rst_all = RST | soft_rst_ff;
  assign idx = PADDR[7:2];
  assign acc = PSEL & PENABLE & pready_ff;
  assign wr = acc & PWRITE;
  assign mapped = (idx >= `IDX_PTR) && (idx <= `IDX_RF);
  assign port_ok = (port_pointer_ff == `PORT_IMPL);

  // ************************************************************
  // Pad synchronisers and debounce
  // ************************************************************
  logic [5:0] meta_ff;
  logic [5:0] sync_ff;
  logic [1:0] deb;

  always_ff @(posedge CLK) begin
    if (rst_all) begin
      meta_ff <= 6'h00;
      sync_ff <= 6'h00;
    end else begin
      meta_ff <= {TWISTED_PAIR_A, TWISTED_PAIR_B, CONNECT_RAW, BIAS_RAW};
      sync_ff <= meta_ff;
    end
  end

  // Debounce only delays the rising edge; a drop clears at once so a
  // pulled cable is never reported as still attached.
  localparam int unsigned DB_CYC [2] = '{BIAS_CYC, CON_CYC};
  logic [31:0] db_cnt_ff [2];

  for (genvar g = 0; g < 2; g++) begin : g_deb
    always_ff @(posedge CLK) begin
      if (rst_all) begin
        db_cnt_ff[g] <= 32'h00000000;
      end else if (!sync_ff[g]) begin
        db_cnt_ff[g] <= 32'h00000000;
      end else if (db_cnt_ff[g] < DB_CYC[g]) begin
        db_cnt_ff[g] <= db_cnt_ff[g] + 32'h00000001;
      end
    end
    assign deb[g] = (db_cnt_ff[g] >= DB_CYC[g]);
  end

  logic bias_deb;
  logic con_deb;
  assign bias_deb = deb[0];
  assign con_deb = deb[1];

  // ************************************************************
  // Tree and self identification validity
  // ************************************************************
  logic tree_ok_ff;
  logic self_ok_ff;

  // Bus reset voids values until the phase completes.
  always_ff @(posedge CLK) begin
    if (rst_all) begin
      tree_ok_ff <= 1'b0;
      self_ok_ff <= 1'b0;
    end else begin
      if (PORT_CTL.bus_reset) begin
        tree_ok_ff <= 1'b0;
      end else if (PORT_CTL.tree_id_done) begin
        tree_ok_ff <= 1'b1;
      end
      if (PORT_CTL.bus_reset) begin
        self_ok_ff <= 1'b0;
      end else if (PORT_CTL.self_id_done) begin
        self_ok_ff <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Pointer, port control and vendor registers
  // ************************************************************
  logic pg0_wr;
  logic pg7_wr;
  logic dis_ff;
  logic evt_en_ff;
  logic fault_ff;
  vendor_ctrl_t vend_ff;

  assign pg0_wr = wr && (page_pointer_ff == `PAGE_PORT) && port_ok;
  assign pg7_wr = wr && (page_pointer_ff == `PAGE_VENDOR);

  // Pointers cleared only by hardware reset.
  always_ff @(posedge CLK) begin
    if (rst_all) begin
      page_pointer_ff <= 3'h0;
      port_pointer_ff <= 4'h0;
    end else if (wr && idx == `IDX_PTR) begin
      page_pointer_ff <= PWDATA[`PAGE_MSB:`PAGE_LSB];
      port_pointer_ff <= PWDATA[`PORT_MSB:`PORT_LSB];
    end
  end

  always_ff @(posedge CLK) begin
    if (rst_all) begin
      dis_ff <= 1'b0;
    end else if (pg0_wr && idx == `IDX_R8) begin
      dis_ff <= PWDATA[`DIS_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (rst_all) begin
      evt_en_ff <= 1'b0;
    end else if (pg0_wr && idx == `IDX_R9) begin
      evt_en_ff <= PWDATA[`EVT_EN_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (rst_all) begin
      vend_ff.null_packet_hold <= 1'b0;
      vend_ff.link_speed <= `LINK_SPEED_RST;
    end else if (pg7_wr && idx == `IDX_R8) begin
      vend_ff.null_packet_hold <= PWDATA[`NPH_BIT];
      vend_ff.link_speed <= PWDATA[`LSPD_MSB:`LSPD_LSB];
    end
  end

  // One-cycle soft reset; the bit itself never reads back.
  always_ff @(posedge CLK) begin
    if (RST) begin
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= pg7_wr && idx == `IDX_RE && PWDATA[`SOFT_RST_BIT];
    end
  end

  // ************************************************************
  // Suspend/resume fault
  // ************************************************************
  logic fault_set;
  logic fault_clr;

  // Checks sample debounced bias at window end.
  assign fault_set = (PORT_CTL.resume_check && !bias_deb) ||
                     (PORT_CTL.suspend_check && bias_deb);
  assign fault_clr = pg0_wr && idx == `IDX_R9 && PWDATA[`FAULT_BIT];

  // A new fault beats a clear in the same cycle.
  always_ff @(posedge CLK) begin
    if (rst_all) begin
      fault_ff <= 1'b0;
    end else if (fault_set) begin
      fault_ff <= 1'b1;
    end else if (fault_clr) begin
      fault_ff <= 1'b0;
    end
  end

  // ************************************************************
  // Port event flag
  // ************************************************************
  logic [3:0] evt_prev_ff;
  logic [3:0] evt_now;
  logic port_event;
  logic evt_flag_ff;

  assign evt_now = {bias_deb, con_deb, dis_ff, fault_ff};
  assign port_event = evt_en_ff && (evt_now != evt_prev_ff);

  always_ff @(posedge CLK) begin
    if (rst_all) begin
      evt_prev_ff <= 4'h0;
    end else begin
      evt_prev_ff <= evt_now;
    end
  end

  // Sticky flag, set wins over the link's clear.
  always_ff @(posedge CLK) begin
    if (rst_all) begin
      evt_flag_ff <= 1'b0;
    end else if (port_event) begin
      evt_flag_ff <= 1'b1;
    end else if (PORT_EVENT_IRQ_CLR) begin
      evt_flag_ff <= 1'b0;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  logic child_view;
  logic [2:0] peer_view;
  logic [7:0] rd_byte;

  // Non-active ports, and the void window, read child.
  assign child_view = !tree_ok_ff || !con_deb || dis_ff ||
                      PORT_CTL.suspended || fault_ff || PORT_CTL.child;
  // Cap at S400; invalid code while unknown.
  assign peer_view = !self_ok_ff ? `PEER_INVALID :
                     (PORT_CTL.peer_speed > `PEER_S400) ? `PEER_S400 :
                     PORT_CTL.peer_speed;

  always_comb begin
    rd_byte = 8'h00;
    if (idx == `IDX_PTR) begin
      rd_byte[`PAGE_MSB:`PAGE_LSB] = page_pointer_ff;
      rd_byte[`PORT_MSB:`PORT_LSB] = port_pointer_ff;
    end else if (page_pointer_ff == `PAGE_PORT) begin
      if (port_ok && idx == `IDX_R8) begin
        rd_byte[`ASTAT_MSB:`ASTAT_LSB] = sync_ff[5:4];
        rd_byte[`BSTAT_MSB:`BSTAT_LSB] = sync_ff[3:2];
        rd_byte[`CHILD_BIT] = child_view;
        rd_byte[`CON_BIT] = con_deb;
        rd_byte[`BIAS_BIT] = bias_deb;
        rd_byte[`DIS_BIT] = dis_ff;
      end else if (port_ok && idx == `IDX_R9) begin
        rd_byte[`PEER_MSB:`PEER_LSB] = peer_view;
        rd_byte[`EVT_EN_BIT] = evt_en_ff;
        rd_byte[`FAULT_BIT] = fault_ff;
      end
    end else if (page_pointer_ff == `PAGE_IDENT) begin
      case (idx)
        `IDX_R8: rd_byte = `COMPLIANCE_LEVEL;
        `IDX_RA: rd_byte = MAKER_OUI[23:16];
        `IDX_RB: rd_byte = MAKER_OUI[15:8];
        `IDX_RC: rd_byte = MAKER_OUI[7:0];
        `IDX_RD: rd_byte = PART_IDENTIFIER[23:16];
        `IDX_RE: rd_byte = PART_IDENTIFIER[15:8];
        `IDX_RF: rd_byte = PART_IDENTIFIER[7:0];
        default: rd_byte = 8'h00;
      endcase
    end else if (page_pointer_ff == `PAGE_VENDOR && idx == `IDX_R8) begin
      // Test locations and soft reset bit read zero.
      rd_byte[`NPH_BIT] = vend_ff.null_packet_hold;
      rd_byte[`LSPD_MSB:`LSPD_LSB] = vend_ff.link_speed;
    end
  end

  // ************************************************************
  // APB answer: one wait state
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (rst_all) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= PSEL && PENABLE && !pready_ff;
      prdata_ff <= (PSEL && !PWRITE && mapped) ? {24'h000000, rd_byte}
                                               : 32'h00000000;
      pslverr_ff <= PSEL && PENABLE && !pready_ff && !mapped;
    end
  end

  assign PREADY = pready_ff;
  assign PRDATA = prdata_ff;
  assign PSLVERR = pslverr_ff;
  assign PORT_EVENT_IRQ_FLAG = evt_flag_ff;
  assign PORT_DISABLE = dis_ff;
  assign FORCE_SUSPEND = fault_ff;
  assign VENDOR_CTRL = vend_ff;
  assign SOFT_HARD_RESET = soft_rst_ff;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (rst_all);

  sequence s_wr(logic [5:0] i, logic [2:0] p);
    wr && idx == i && page_pointer_ff == p;
  endsequence

  sequence s_rd_done(logic [5:0] i, logic [2:0] p);
    acc && !PWRITE && idx == i && page_pointer_ff == p;
  endsequence

  a_ready_one_cycle: assert property (
    pready_ff |=> !pready_ff)
    else $error("pready held longer than one cycle");
  a_unimpl_port_zero: assert property (
    s_rd_done(`IDX_R8, `PAGE_PORT) and !port_ok |-> PRDATA == 32'h0)
    else $error("unimplemented port read nonzero");
  a_ident_maker_hi: assert property (
    s_rd_done(`IDX_RA, `PAGE_IDENT) |-> PRDATA[7:0] == MAKER_OUI[23:16])
    else $error("maker code high byte wrong");
  a_compliance_read: assert property (
    s_rd_done(`IDX_R8, `PAGE_IDENT) |-> PRDATA[7:0] == `COMPLIANCE_LEVEL)
    else $error("compliance level wrong");
  a_swr_reads_zero: assert property (
    s_rd_done(`IDX_RE, `PAGE_VENDOR) |-> PRDATA == 32'h0)
    else $error("soft reset location read nonzero");
  a_fault_resume: assert property (
    PORT_CTL.resume_check && !bias_deb |=> fault_ff && FORCE_SUSPEND)
    else $error("resume fault not flagged");
  a_fault_suspend: assert property (
    PORT_CTL.suspend_check && bias_deb |=> fault_ff)
    else $error("suspend fault not flagged");
  a_fault_clear: assert property (
    s_wr(`IDX_R9, `PAGE_PORT) and port_ok && PWDATA[`FAULT_BIT]
      && !fault_set |=> !fault_ff)
    else $error("fault not cleared by write of one");
  a_event_sets_flag: assert property (
    port_event |=> PORT_EVENT_IRQ_FLAG ##1 PORT_EVENT_IRQ_FLAG
      || $past(PORT_EVENT_IRQ_CLR))
    else $error("port event flag not set");
  a_bias_debounce: assert property (
    $rose(bias_deb) |-> $past(db_cnt_ff[0]) == BIAS_CYC - 1)
    else $error("bias rose before debounce time");
  a_child_on_disable: assert property (
    s_rd_done(`IDX_R8, `PAGE_PORT) and port_ok && dis_ff
      |-> PRDATA[`CHILD_BIT])
    else $error("disabled port not reported as child");
  a_peer_void: assert property (
    PORT_CTL.bus_reset |=> peer_view == `PEER_INVALID)
    else $error("peer speed valid right after bus reset");

endmodule // phy_paged_port_vendor_regs
`default_nettype wire

// ==== src/phy_paged_defs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the
//          paged port/identification/vendor register bank.
// Assumes: 100 MHz CLK; register index times four is the APB byte address.
// Notes:   Field bit 0 of each 8-bit register is its least significant bit.
`ifndef PHY_PAGED_DEFS_SVH
`define PHY_PAGED_DEFS_SVH

// ************************************************************
// Register indices
// ************************************************************
`define IDX_PTR 6'h07
`define IDX_R8 6'h08
`define IDX_R9 6'h09
`define IDX_RA 6'h0A
`define IDX_RB 6'h0B
`define IDX_RC 6'h0C
`define IDX_RD 6'h0D
`define IDX_RE 6'h0E
`define IDX_RF 6'h0F

// ************************************************************
// Pointer register fields and page codes
// ************************************************************
`define PAGE_MSB 7
`define PAGE_LSB 5
`define PORT_MSB 3
`define PORT_LSB 0
`define PAGE_PORT 3'h0
`define PAGE_IDENT 3'h1
`define PAGE_VENDOR 3'h7
`define PORT_IMPL 4'h0

// ************************************************************
// Port status page fields
// ************************************************************
`define ASTAT_MSB 7
`define ASTAT_LSB 6
`define BSTAT_MSB 5
`define BSTAT_LSB 4
`define CHILD_BIT 3
`define CON_BIT 2
`define BIAS_BIT 1
`define DIS_BIT 0
`define PEER_MSB 7
`define PEER_LSB 5
`define EVT_EN_BIT 4
`define FAULT_BIT 3
`define PEER_S400 3'h2
`define PEER_INVALID 3'h7

// ************************************************************
// Identification and vendor page fields
// ************************************************************
`define COMPLIANCE_LEVEL 8'h01
`define NPH_BIT 7
`define LSPD_MSB 1
`define LSPD_LSB 0
`define LINK_SPEED_RST 2'h2
`define SOFT_RST_BIT 7

// ************************************************************
// Timing
// ************************************************************
`define CLK_MHZ 100
`define CON_DEBOUNCE_MS 341
`define CON_DEBOUNCE_CYC (`CON_DEBOUNCE_MS * 1000 * `CLK_MHZ)
`define BIAS_DEBOUNCE_US 52
`define BIAS_DEBOUNCE_CYC (`BIAS_DEBOUNCE_US * `CLK_MHZ)

`endif

// ==== src/phy_paged_pkg.sv ====
// Purpose: Types shared by the paged register bank and its bench.
// Assumes: Nothing beyond the defs header.
// Notes:   Port-side inputs travel as one packed struct.
`default_nettype none
package phy_paged_pkg;

  // Port logic inputs, all on the CLK domain.
  typedef struct packed {
    logic child;
    logic [2:0] peer_speed;
    logic suspended;
    logic bus_reset;
    logic tree_id_done;
    logic self_id_done;
    logic resume_check;
    logic suspend_check;
  } port_ctl_in_t;

  // Vendor page controls driven to the rest of the device.
  typedef struct packed {
    logic null_packet_hold;
    logic [1:0] link_speed;
  } vendor_ctrl_t;

endpackage
`default_nettype wire

// ==== tb/llc_apb_master.sv ====
// Purpose: Link-side register master that reaches the bank over APB.
// Assumes: One clock; requests launched just after a rising edge.
// Notes:   A request stands until PREADY is seen high at a rising edge, or for at most 64 edges.
`default_nettype none
module link_apb_master (
  input wire logic CLK,
  output logic PSEL,
  output logic PENABLE,
  output logic PWRITE,
  output logic [7:0] PADDR,
  output logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
  end

  task automatic xfer(input logic wr, input logic [5:0] idx,
    input logic [7:0] wd, output logic [31:0] rd, output logic err,
    output logic hung);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= {idx, 2'b00};
    PWDATA <= {24'h0, wd};
    @(posedge CLK);
    PENABLE <= 1'b1;
    // Each pass reads PREADY as sampled at this rising edge, before the
    // slave's registers move, so data are taken at the completing edge.
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 64);
    hung = (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
endmodule // link_apb_master
`default_nettype wire

// ==== tb/phy_paged_port_vendor_regs_bench.sv ====
// Purpose: Self-checking bench for the paged register bank.
// Assumes: Short debounce counts so the run stays brief.
// Notes:   Expected values come from the field layout, not the design.
`default_nettype none
`include "phy_paged_defs.svh"
module phy_paged_port_vendor_regs_bench;
  import phy_paged_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Signals and instances
  // ************************************************************
  localparam int P_BR = 4;
  localparam int P_TID = 3;
  localparam int P_SID = 2;
  localparam int P_RC = 1;
  localparam int P_SC = 0;
  // Arbitrary identity values.
  localparam logic [23:0] OUI = 24'h3C5A11;
  localparam logic [23:0] PID = 24'h7E0142;
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] pair_a, pair_b;
  logic con_raw, bias_raw, irq_clr, irq, dis, fsusp, soft_rst;
  port_ctl_in_t ctl;
  vendor_ctrl_t vctl;
  int error_cnt = 0;
  int total_checks = 0;
  int soft_rst_cnt = 0;

  phy_paged_port_vendor_regs #(.CON_CYC(20), .BIAS_CYC(10),
    .MAKER_OUI(OUI), .PART_IDENTIFIER(PID))
  phy_paged_port_vendor_regs_inst (.CLK(clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TWISTED_PAIR_A(pair_a), .TWISTED_PAIR_B(pair_b), .CONNECT_RAW(con_raw),
    .BIAS_RAW(bias_raw), .PORT_CTL(ctl), .PORT_EVENT_IRQ_CLR(irq_clr),
    .PORT_EVENT_IRQ_FLAG(irq), .PORT_DISABLE(dis), .FORCE_SUSPEND(fsusp),
    .VENDOR_CTRL(vctl), .SOFT_HARD_RESET(soft_rst));

  link_apb_master link_apb_master_inst (.CLK(clk), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (soft_rst === 1'b1) begin
      soft_rst_cnt <= soft_rst_cnt + 1;
    end
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string what, input logic [39:0] exp,
    input logic [39:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [5:0] idx, input logic e_err,
    input logic [7:0] exp, input string what);
    logic [31:0] d;
    logic e, h;
    link_apb_master_inst.xfer(1'b0, idx, 8'h00, d, e, h);
    chk(what, {6'h0, 1'b0, e_err, 24'h0, exp}, {6'h0, h, e, d});
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    logic e, h;
    link_apb_master_inst.xfer(1'b1, idx, wd, d, e, h);
    chk("write status", 40'h0, {38'h0, h, e});
  endtask

  task automatic pulse(input int b);
    @(posedge clk);
    ctl[b] <= 1'b1;
    @(posedge clk);
    ctl[b] <= 1'b0;
  endtask

  task automatic clr_irq();
    @(posedge clk);
    irq_clr <= 1'b1;
    @(posedge clk);
    irq_clr <= 1'b0;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    rd(`IDX_PTR, 1'b0, 8'h00, "pointer");
    rd(6'h00, 1'b1, 8'h00, "base reg");
    rd(6'h10, 1'b1, 8'h00, "past top");
    wr(`IDX_PTR, 8'hE0);
    rd(`IDX_R8, 1'b0, 8'h02, "link speed");
    $display("test reset done");
  endtask

  task automatic t_ident();
    wr(`IDX_PTR, 8'h20);
    rd(`IDX_R8, 1'b0, 8'h01, "compliance");
    wr(`IDX_R9, 8'hFF);
    rd(`IDX_R9, 1'b0, 8'h00, "ident rsvd");
    for (int i = 0; i < 3; i++) begin
      rd(6'(`IDX_RA + i), 1'b0, OUI[23 - 8 * i -: 8], "maker");
      rd(6'(`IDX_RD + i), 1'b0, PID[23 - 8 * i -: 8], "part");
    end
    wr(`IDX_PTR, 8'h00);
    $display("test ident done");
  endtask

  task automatic t_port();
    pulse(P_TID);
    @(posedge clk);
    con_raw <= 1'b1;
    bias_raw <= 1'b1;
    rd(`IDX_R8, 1'b0, 8'h08, "early debounce");
    repeat (40) @(posedge clk);
    rd(`IDX_R8, 1'b0, 8'h06, "debounced");
    pulse(P_BR);
    rd(`IDX_R8, 1'b0, 8'h0E, "tree invalid");
    pulse(P_TID);
    rd(`IDX_R8, 1'b0, 8'h06, "tree valid");
    @(posedge clk);
    ctl.child <= 1'b1;
    rd(`IDX_R8, 1'b0, 8'h0E, "child port");
    @(posedge clk);
    ctl.child <= 1'b0;
    ctl.suspended <= 1'b1;
    rd(`IDX_R8, 1'b0, 8'h0E, "suspended");
    @(posedge clk);
    ctl.suspended <= 1'b0;
    chk("irq idle", 40'h0, 40'(irq));
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      pair_a <= 2'(c);
      pair_b <= ~2'(c);
      repeat (4) @(posedge clk);
      rd(`IDX_R8, 1'b0, {2'(c), ~2'(c), 4'h6}, "lines");
    end
    wr(`IDX_R8, 8'h01);
    // The register moves at the completing edge; look once it settles.
    @(negedge clk);
    chk("disable out", 40'h1, 40'(dis));
    pulse(P_BR);
    pulse(P_TID);
    rd(`IDX_R8, 1'b0, 8'hCF, "disabled");
    wr(`IDX_R8, 8'h00);
    wr(`IDX_PTR, 8'h01);
    rd(`IDX_R8, 1'b0, 8'h00, "no port r8");
    rd(`IDX_R9, 1'b0, 8'h00, "no port r9");
    wr(`IDX_PTR, 8'h00);
    ctl.peer_speed <= 3'b101;
    pulse(P_SID);
    rd(`IDX_R9, 1'b0, 8'h40, "peer clamp");
    ctl.peer_speed <= 3'b001;
    pulse(P_SID);
    rd(`IDX_R9, 1'b0, 8'h20, "peer s200");
    pulse(P_BR);
    rd(`IDX_R9, 1'b0, 8'hE0, "peer invalid");
    pulse(P_SID);
    $display("test port done");
  endtask

  task automatic t_fault();
    wr(`IDX_R9, 8'h10);
    pulse(P_SC);
    repeat (2) @(posedge clk);
    chk("suspend fault", 40'h1, 40'(fsusp));
    chk("event flag", 40'h1, 40'(irq));
    rd(`IDX_R9, 1'b0, 8'h38, "fault set");
    wr(`IDX_R9, 8'h18);
    rd(`IDX_R9, 1'b0, 8'h30, "fault clear");
    chk("suspend off", 40'h0, 40'(fsusp));
    clr_irq();
    @(posedge clk);
    chk("flag cleared", 40'h0, 40'(irq));
    @(posedge clk);
    bias_raw <= 1'b0;
    repeat (6) @(posedge clk);
    pulse(P_RC);
    repeat (2) @(posedge clk);
    chk("resume fault", 40'h1, 40'(fsusp));
    pulse(P_BR);
    rd(`IDX_R9, 1'b0, 8'hF8, "fault kept");
    wr(`IDX_R9, 8'h08);
    rd(`IDX_R9, 1'b0, 8'hE0, "all clear");
    clr_irq();
    $display("test fault done");
  endtask

  task automatic t_vendor();
    wr(`IDX_PTR, 8'hE0);
    wr(`IDX_R8, 8'h81);
    @(negedge clk);
    chk("vendor ctrl", 40'h5, 40'(vctl));
    rd(`IDX_R8, 1'b0, 8'h81, "vendor r8");
    for (int i = 9; i < 16; i++) begin
      if (i != 14) begin
        wr(6'(i), 8'hFF);
      end
      rd(6'(i), 1'b0, 8'h00, "test rsvd");
    end
    wr(`IDX_RE, 8'h80);
    repeat (3) @(posedge clk);
    chk("soft pulse", 40'h1, 40'(soft_rst_cnt));
    chk("speed reset", 40'h2, 40'(vctl));
    rd(`IDX_PTR, 1'b0, 8'h00, "ptr reset");
    $display("test vendor done");
  endtask

  // ************************************************************
  // Sequence and verdict
  // ************************************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #300000;
    error_cnt++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    pair_a = 2'b00;
    pair_b = 2'b00;
    con_raw = 1'b0;
    bias_raw = 1'b0;
    irq_clr = 1'b0;
    ctl = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_ident();
    t_port();
    t_fault();
    t_vendor();
    finish_test();
  end
endmodule // phy_paged_port_vendor_regs_bench
`default_nettype wire
